// ==== hw/tcc_regs.vh ====
// Register map, field positions, reset values and timing for the channel
`ifndef TCC_REGS_VH
`define TCC_REGS_VH
// Register indices; not all are multiples of four
`define TCC_IDX_RUN        16'hf030
`define TCC_IDX_CTRL       16'hf040
`define TCC_IDX_MODE       16'hf041
`define TCC_IDX_IOFN       16'hf042
`define TCC_IDX_CNT        16'hf046
`define TCC_IDX_CMPA       16'hf048
// Byte addresses, four times the index
`define TCC_ADDR_RUN       18'h3c0c0
`define TCC_ADDR_CTRL      18'h3c100
`define TCC_ADDR_MODE      18'h3c104
`define TCC_ADDR_IOFN      18'h3c108
`define TCC_ADDR_CNT       18'h3c118
`define TCC_ADDR_CMPA      18'h3c120
// Field positions
`define TCC_RUN_BIT        1
`define TCC_CLR_HI         6
`define TCC_CLR_LO         5
`define TCC_PSC_HI         2
`define TCC_PSC_LO         0
`define TCC_MODE_HI        1
`define TCC_MODE_LO        0
`define TCC_FN_HI          3
`define TCC_FN_LO          0
// Field codes
`define TCC_CLR_CMPA       2'h1
`define TCC_PSC_DIV4       3'h1
`define TCC_MODE_NORMAL    2'h0
`define TCC_FN_TOGGLE      4'h3
// Reset values
`define TCC_RST_CNT        16'h0000
`define TCC_RST_CMPA       16'hffff
`define TCC_RST_BYTE       8'h00
// Prescale: one enable per four clocks
`define TCC_DIV4_CYCLES    2'h3
`endif

// ==== hw/tcc_prescale.v ====
// Divide-by-four count enable pulse generator
`timescale 1ns/1ns
`include "tcc_regs.vh"
module tcc_prescale (
    // Clock and reset
    input  wire       ref_clk_in,
    input  wire       rst_in,
    // Control
    input  wire       run_in,
    // Enable pulse
    output reg        tick_out
);
    reg [1:0] div_q;

    // Divider free-runs only while run_in is high, so start phase is fixed
    always @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            div_q    <= 2'h0;
            tick_out <= 1'b0;
        end else if (!run_in) begin
            div_q    <= 2'h0;
            tick_out <= 1'b0;
        end else begin
            tick_out <= (div_q == `TCC_DIV4_CYCLES);
            div_q    <= div_q + 2'h1;
        end
    end
endmodule // tcc_prescale

// ==== hw/tcc_channel.v ====
// Timer channel with compare-match toggle output and APB registers
//
// Notes on behaviour
// - Function code 0011 makes pin compare output
// - Pin starts low, toggles on each match
// - Counter is 16-bit read/write, reset zero
// - General register is 16-bit read/write compare
// - General register resets to all ones
// - Clear select 01 clears counter on match
// - Prescale 001 counts at clock over four
// - Counter runs only while run bit set
// - Mode 00 selects normal up counting
//
// The implementer's own choice: the APB register port.
`timescale 1ns/1ns
`include "tcc_regs.vh"
module tcc_channel (
    // Clock and reset
    input  wire        ref_clk_in,
    input  wire        rst_in,
    // APB slave
    input  wire        psel_in,
    input  wire        penable_in,
    input  wire        pwrite_in,
    input  wire [17:0] paddr_in,
    input  wire [31:0] pwdata_in,
    output reg  [31:0] prdata_out,
    output reg         pready_out,
    output reg         pslverr_out,
    // Pin
    output reg         compare_toggle_pin_out,
    output reg         compare_toggle_pin_oe_out
);
    reg  [7:0]  counter_run_control_q;
    reg  [7:0]  channel_control_q;
    reg  [7:0]  channel_mode_reg_q;
    reg  [7:0]  channel_io_function_q;
    reg  [15:0] channel_counter_q;
    reg  [15:0] channel_compare_a_q;
    reg  [15:0] cnt_d;
    reg  [31:0] rd_d;
    reg         hit_d;
    wire        tick;
    wire        run;
    wire        toggle_mode;
    wire        clear_on_match;
    wire        psc_div4;
    wire        mode_normal;
    wire        count_cfg;
    wire        match;
    wire        access_first;
    wire        wr;
    wire        cnt_wr;
    wire        sel_run;
    wire        sel_ctrl;
    wire        sel_mode;
    wire        sel_iofn;
    wire        sel_cnt;
    wire        sel_cmpa;
    wire        sel_any;

    // Address decode, one select per register
    assign sel_run  = (paddr_in == `TCC_ADDR_RUN);
    assign sel_ctrl = (paddr_in == `TCC_ADDR_CTRL);
    assign sel_mode = (paddr_in == `TCC_ADDR_MODE);
    assign sel_iofn = (paddr_in == `TCC_ADDR_IOFN);
    assign sel_cnt  = (paddr_in == `TCC_ADDR_CNT);
    assign sel_cmpa = (paddr_in == `TCC_ADDR_CMPA);
    // Unmapped addresses answer with an error and no side effect
    assign sel_any  = sel_run | sel_ctrl | sel_mode | sel_iofn
                    | sel_cnt | sel_cmpa;

    // Field decode of the run, control and mode registers
    assign run = counter_run_control_q[`TCC_RUN_BIT];
    assign clear_on_match = (channel_control_q[`TCC_CLR_HI:`TCC_CLR_LO]
                             == `TCC_CLR_CMPA);
    assign psc_div4 = (channel_control_q[`TCC_PSC_HI:`TCC_PSC_LO]
                       == `TCC_PSC_DIV4);
    assign mode_normal = (channel_mode_reg_q[`TCC_MODE_HI:`TCC_MODE_LO]
                          == `TCC_MODE_NORMAL);
    // Other clock sources and modes are not built, so they stall the count
    assign count_cfg = run && psc_div4 && mode_normal;
    // Pin function decode
    assign toggle_mode = (channel_io_function_q[`TCC_FN_HI:`TCC_FN_LO]
                          == `TCC_FN_TOGGLE);
    assign match = tick && (channel_counter_q == channel_compare_a_q);
    // First access cycle: the one edge at which a transfer acts
    assign access_first = psel_in && penable_in && !pready_out;
    assign wr = access_first && pwrite_in;
    assign cnt_wr = wr && sel_cnt;

    // Count enable; stopped divider restarts in phase on run
    tcc_prescale u_div (
        .ref_clk_in (ref_clk_in),
        .rst_in     (rst_in),
        .run_in     (run),
        .tick_out   (tick)
    );

    // Next counter value; a software write beats the count
    always @* begin
        cnt_d = channel_counter_q;
        if (tick && count_cfg) begin
            if (match && clear_on_match)
                cnt_d = 16'h0000;
            else
                cnt_d = channel_counter_q + 16'h0001;
        end
    end

    // Match qualified by the same count conditions
    always @* begin
        hit_d = match && count_cfg;
    end

    // Counter register; a software write lands at the edge that raises
    // pready and wins over a count in the same cycle
    always @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            channel_counter_q <= `TCC_RST_CNT;
        end else if (cnt_wr) begin
            channel_counter_q <= pwdata_in[15:0];
        end else begin
            channel_counter_q <= cnt_d;
        end
    end

    // Run control; only the run bit acts, the rest is storage
    always @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            counter_run_control_q <= `TCC_RST_BYTE;
        end else if (wr && sel_run) begin
            counter_run_control_q <= pwdata_in[7:0];
        end
    end

    // Channel control: clear select, edge bits, prescale select
    always @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            channel_control_q <= `TCC_RST_BYTE;
        end else if (wr && sel_ctrl) begin
            channel_control_q <= pwdata_in[7:0];
        end
    end

    // Channel mode
    always @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            channel_mode_reg_q <= `TCC_RST_BYTE;
        end else if (wr && sel_mode) begin
            channel_mode_reg_q <= pwdata_in[7:0];
        end
    end

    // Pin function; leaving 0011 drops the pin low and releases it
    always @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            channel_io_function_q <= `TCC_RST_BYTE;
        end else if (wr && sel_iofn) begin
            channel_io_function_q <= pwdata_in[7:0];
        end
    end

    // Compare register; full word write only, no byte lanes exist
    always @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            channel_compare_a_q <= `TCC_RST_CMPA;
        end else if (wr && sel_cmpa) begin
            channel_compare_a_q <= pwdata_in[15:0];
        end
    end

    // Pin: low until toggle mode chosen, then flips on each match
    always @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            compare_toggle_pin_out    <= 1'b0;
            compare_toggle_pin_oe_out <= 1'b0;
        end else if (!toggle_mode) begin
            compare_toggle_pin_out    <= 1'b0;
            compare_toggle_pin_oe_out <= 1'b0;
        end else begin
            compare_toggle_pin_oe_out <= 1'b1;
            // First enabled cycle always shows the low start level
            if (hit_d && compare_toggle_pin_oe_out)
                compare_toggle_pin_out <= ~compare_toggle_pin_out;
        end
    end

    // Read mux; unmapped addresses read zero with an error
    // A counter read returns the value at the first access edge
    always @* begin
        rd_d = 32'h00000000;
        case (paddr_in)
            `TCC_ADDR_RUN:  rd_d = {24'h000000, counter_run_control_q};
            `TCC_ADDR_CTRL: rd_d = {24'h000000, channel_control_q};
            `TCC_ADDR_MODE: rd_d = {24'h000000, channel_mode_reg_q};
            `TCC_ADDR_IOFN: rd_d = {24'h000000, channel_io_function_q};
            `TCC_ADDR_CNT:  rd_d = {16'h0000, channel_counter_q};
            `TCC_ADDR_CMPA: rd_d = {16'h0000, channel_compare_a_q};
            default:        rd_d = 32'h00000000;
        endcase
    end

    // One wait state: ready one cycle into the access phase
    // Fixed answer time keeps the decode free of any state machine
    always @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            pready_out  <= 1'b0;
            pslverr_out <= 1'b0;
            prdata_out  <= 32'h00000000;
        end else if (access_first) begin
            pready_out  <= 1'b1;
            prdata_out  <= pwrite_in ? 32'h00000000 : rd_d;
            pslverr_out <= !sel_any;
        end else begin
            pready_out  <= 1'b0;
            pslverr_out <= 1'b0;
        end
    end
endmodule // tcc_channel

// ==== bench/tcc_pin_load.sv ====
// Load model on the toggle pin: counts edges and clocks between them
`timescale 1ns/1ns
module tcc_pin_load (
    // Clock and reset
    input  wire        ref_clk_in,
    input  wire        rst_in,
    // Pin, pulled low while not driven
    input  wire        pin_in,
    input  wire        oe_in,
    // Measurements
    output reg  [15:0] edges_out,
    output reg  [15:0] gap_out
);
    wire       level = pin_in & oe_in;
    reg        last_q;
    reg [15:0] run_q;
    // Edge counter; gap holds the last full half period
    always @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            last_q    <= 1'b0;
            run_q     <= 16'h0000;
            edges_out <= 16'h0000;
            gap_out   <= 16'h0000;
        end else if (level != last_q) begin
            last_q    <= level;
            run_q     <= 16'h0001;
            edges_out <= edges_out + 16'h0001;
            gap_out   <= run_q;
        end else begin
            run_q <= run_q + 16'h0001;
        end
    end
endmodule // tcc_pin_load

// ==== bench/tcc_channel_asserts.sv ====
// Port-level assertions for the compare toggle channel
`timescale 1ns/1ns
`include "tcc_regs.vh"
module tcc_channel_chk (
    // Clock and reset
    input wire        ref_clk_in,
    input wire        rst_in,
    // APB
    input wire        psel_in,
    input wire        penable_in,
    input wire        pwrite_in,
    input wire [17:0] paddr_in,
    input wire [31:0] pwdata_in,
    input wire [31:0] prdata_out,
    input wire        pready_out,
    input wire        pslverr_out,
    // Pin
    input wire        compare_toggle_pin_out,
    input wire        compare_toggle_pin_oe_out
);
    wire pin = compare_toggle_pin_out;
    wire oe  = compare_toggle_pin_oe_out;
    // Decode kept here so error replies can be judged
    wire wide = paddr_in == `TCC_ADDR_CNT || paddr_in == `TCC_ADDR_CMPA;
    wire map  = wide || paddr_in == `TCC_ADDR_RUN
        || paddr_in == `TCC_ADDR_CTRL || paddr_in == `TCC_ADDR_MODE
        || paddr_in == `TCC_ADDR_IOFN;
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (rst_in);
    ready_pulse_a: assert property (pready_out |=> !pready_out)
        else $error("pready too long");
    ready_cause_a: assert property (pready_out |-> $past(penable_in))
        else $error("pready without access");
    err_unmapped_a: assert property
        (pready_out && !map |-> pslverr_out) else $error("no error");
    err_only_a: assert property
        (pslverr_out |-> pready_out && map == 1'b0) else $error("bad error");
    read_pad_a: assert property
        (pready_out && !pwrite_in && wide |-> prdata_out[31:16] == 16'h0000)
        else $error("upper half set");
    pin_idle_a: assert property (!oe |-> !pin)
        else $error("pin high while off");
    start_low_a: assert property ($rose(oe) |-> !pin)
        else $error("pin not low at start");
    toggle_gap_a: assert property
        ($changed(pin) && oe |=> (!oe || $stable(pin))[*3])
        else $error("toggles too close");
    cover property ($changed(pin) && oe);
    cover property (pslverr_out);
    cover property (pready_out && !pwrite_in && wide);
endmodule // tcc_channel_chk
bind tcc_channel tcc_channel_chk chk (.ref_clk_in(ref_clk_in),
    .rst_in(rst_in), .psel_in(psel_in), .penable_in(penable_in),
    .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in),
    .prdata_out(prdata_out), .pready_out(pready_out),
    .pslverr_out(pslverr_out),
    .compare_toggle_pin_out(compare_toggle_pin_out),
    .compare_toggle_pin_oe_out(compare_toggle_pin_oe_out));

// ==== bench/tb.sv ====
// Register-level bench for the compare toggle channel
`timescale 1ns/1ns
`include "tcc_regs.vh"
module tb;
    reg         ref_clk_in = 1'b0;
    reg         rst_in     = 1'b1;
    reg         psel_in    = 1'b0;
    reg         penable_in = 1'b0;
    reg         pwrite_in  = 1'b0;
    reg  [17:0] paddr_in   = 18'h00000;
    reg  [31:0] pwdata_in  = 32'h00000000;
    wire [31:0] prdata_out;
    wire        pready_out, pslverr_out, pin, oe;
    wire [15:0] edges, gap;
    reg  [31:0] rd, held;
    reg         err;
    integer     fails = 0, num_checks = 0, i;
    // 250 MHz clock
    always #2 ref_clk_in = ~ref_clk_in;
    tcc_channel uut (.ref_clk_in(ref_clk_in), .rst_in(rst_in),
        .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in),
        .paddr_in(paddr_in), .pwdata_in(pwdata_in), .prdata_out(prdata_out),
        .pready_out(pready_out), .pslverr_out(pslverr_out),
        .compare_toggle_pin_out(pin), .compare_toggle_pin_oe_out(oe));
    tcc_pin_load load (.ref_clk_in(ref_clk_in), .rst_in(rst_in),
        .pin_in(pin), .oe_in(oe), .edges_out(edges), .gap_out(gap));
    task wrap_up;
        begin
            if (fails == 0 && num_checks > 0)
                $display("All checks passed");
            else
                $display("Checks failed");
            $finish;
        end
    endtask
    task check(input [31:0] seen, input [31:0] exp);
        begin
            num_checks = num_checks + 1;
            if (seen !== exp) begin
                fails = fails + 1;
                $display("CHECK FAILED %0t %h %h", $time, seen, exp);
            end
        end
    endtask
    // Whole-word APB transfer, so wide registers never go bytewise
    task xfer(input wr, input [17:0] a, input [31:0] d);
        begin
            @(posedge ref_clk_in);
            psel_in   <= 1'b1;
            pwrite_in <= wr;
            paddr_in  <= a;
            pwdata_in <= d;
            @(posedge ref_clk_in);
            penable_in <= 1'b1;
            i = 0;
            do begin
                @(posedge ref_clk_in);
                i = i + 1;
            end while (pready_out !== 1'b1 && i < 20);
            if (i >= 20) begin
                fails = fails + 1;
                wrap_up;
            end
            rd = prdata_out;
            err = pslverr_out;
            psel_in    <= 1'b0;
            penable_in <= 1'b0;
        end
    endtask
    initial begin
        repeat (16) @(posedge ref_clk_in);
        rst_in <= 1'b0;
        // Reset values, read-back, upper half ignored
        xfer(0, `TCC_ADDR_CNT, 0);
        check(rd, 32'h0000);
        xfer(0, `TCC_ADDR_CMPA, 0);
        check(rd, 32'hffff);
        xfer(1, `TCC_ADDR_CMPA, 32'h5a5a1234);
        xfer(0, `TCC_ADDR_CMPA, 0);
        check(rd, 32'h1234);
        xfer(1, `TCC_ADDR_CNT, 32'hffffabcd);
        xfer(0, `TCC_ADDR_CNT, 0);
        check(rd, 32'habcd);
        xfer(0, 18'h3c0c4, 0);
        check(rd, 32'h0);
        check({31'h0, err}, 32'h1);
        // Clear on match at two, clock over four: 12-clock halves
        xfer(1, `TCC_ADDR_CMPA, 32'h2);
        xfer(1, `TCC_ADDR_CNT, 32'h0);
        xfer(1, `TCC_ADDR_CTRL, 32'h21);
        xfer(1, `TCC_ADDR_MODE, 32'h0);
        xfer(1, `TCC_ADDR_IOFN, 32'h3);
        repeat (2) @(posedge ref_clk_in);
        check({oe, pin}, 32'h2);
        xfer(1, `TCC_ADDR_RUN, 32'h2);
        for (i = 0; i < 400 && edges < 4; i = i + 1) @(posedge ref_clk_in);
        check(edges, 32'd4);
        check(gap, 32'd12);
        // Stopped counter holds its value
        xfer(1, `TCC_ADDR_RUN, 32'h0);
        xfer(0, `TCC_ADDR_CNT, 0);
        held = rd;
        repeat (40) @(posedge ref_clk_in);
        xfer(0, `TCC_ADDR_CNT, 0);
        check(rd, held);
        // No clear: fffe runs through ffff and wraps onto a match at zero
        xfer(1, `TCC_ADDR_CTRL, 32'h1);
        xfer(1, `TCC_ADDR_CMPA, 32'h0);
        xfer(1, `TCC_ADDR_CNT, 32'hfffe);
        held = edges;
        xfer(1, `TCC_ADDR_RUN, 32'h2);
        repeat (20) @(posedge ref_clk_in);
        check(edges, held + 1);
        xfer(1, `TCC_ADDR_IOFN, 32'h0);
        repeat (2) @(posedge ref_clk_in);
        check({oe, pin}, 32'h0);
        // Reset in mid-run, counter still running: reset values return
        rst_in <= 1'b1;
        repeat (3) @(posedge ref_clk_in);
        rst_in <= 1'b0;
        xfer(0, `TCC_ADDR_CNT, 0);
        check(rd, 32'h0000);
        xfer(0, `TCC_ADDR_CMPA, 0);
        check(rd, 32'hffff);
        xfer(0, `TCC_ADDR_RUN, 0);
        check(rd, 32'h0);
        check({oe, pin}, 32'h0);
        wrap_up;
    end
endmodule // tb
